// ---- design/amst_cfg.svh ----
// constants for the asynchronous memory strobe sequencer
// Functional notes
// - read lasts setup plus strobe plus hold
// - wait extends read by sixteen per unit
// - select leads and trails output enable
// - select-strobe mode: select tracks output enable
// - word address valid setup before enable
// - word address held hold after enable
// - bank address setup and hold around enable
// - output enable low strobe plus extension
// - enable rises four after wait release
// - write lasts setup plus strobe plus hold
// - wait extends write by sixteen per unit
// - select leads and trails write strobe
// - select-strobe mode: select tracks write strobe
// - word address valid setup before strobe
// - word address held hold after strobe
// - bank address setup and hold around strobe
// - write data driven setup before strobe
// - write data held hold after strobe
// - write strobe low strobe plus extension
// - write strobe rises four after wait
// - all phases counted in system clocks
// - wait stretching stops at programmed limit
// - all counts except the fixed sixteen-cycle extension unit and four-cycle wait sample point come from software registers
`ifndef AMST_CFG_SVH
`define AMST_CFG_SVH

`define AMST_CLK_PERIOD_NS 5
`define AMST_EXT_UNIT      8'h10
`define AMST_WAIT_SAMPLE   8'h04
`define AMST_WAIT_FULL     9'h100

`define AMST_OFF_CTRL      8'h00
`define AMST_OFF_ADDR      8'h04
`define AMST_OFF_WDATA     8'h08
`define AMST_OFF_TIMING    8'h0c
`define AMST_OFF_WAITCFG   8'h10
`define AMST_OFF_STATUS    8'h14
`define AMST_OFF_RDATA     8'h18

`define AMST_CTRL_GO       0
`define AMST_CTRL_WR       1
`define AMST_CTRL_SS       2
`define AMST_CTRL_EW       3

`define AMST_ADDR_BANK_LSB 21
`define AMST_ADDR_CS_LSB   24

`define AMST_RS_LSB        0
`define AMST_RS_W          4
`define AMST_RST_LSB       4
`define AMST_RST_W         6
`define AMST_RH_LSB        10
`define AMST_RH_W          4
`define AMST_WS_LSB        14
`define AMST_WS_W          4
`define AMST_WST_LSB       18
`define AMST_WST_W         6
`define AMST_WH_LSB        24
`define AMST_WH_W          4
`define AMST_TA_LSB        28
`define AMST_TA_W          4

`define AMST_ST_BUSY       0
`define AMST_ST_TIMEOUT    1
`define AMST_ST_DONE       2
`define AMST_ST_EWC_LSB    8

`define AMST_TIMING_RST    32'h0000_0000
`define AMST_WAITCFG_RST   8'h00
`define AMST_CTRL_RST      4'h0

`endif

// ---- design/amst_pkg.sv ----
// types of the asynchronous memory strobe sequencer
package amst_pkg;

  typedef enum logic [2:0] {
    AMST_IDLE,
    AMST_SETUP,
    AMST_STROBE,
    AMST_EXTEND,
    AMST_HOLD,
    AMST_TURN
  } amst_phase_t;

endpackage

// ---- design/amst_phase_cnt.sv ----
// loadable down counter timing one access phase
`timescale 1ns/1ps
module amst_phase_cnt #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // state
  output logic      [W-1:0] cnt,
  output logic              last
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } amst_cnt_state_t;

  amst_cnt_state_t s_r;
  amst_cnt_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (load)
    begin
      s_nxt.cnt = load_val;
    end
    else if (s_r.cnt != '0)
    begin
      s_nxt.cnt = s_r.cnt - W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign cnt  = s_r.cnt;
  assign last = (s_r.cnt == W'(1));

endmodule

// ---- design/amst_ctrl.sv ----
// asynchronous memory strobe sequencer with apb registers
`timescale 1ns/1ps
`include "amst_cfg.svh"
module amst_ctrl #(
  parameter int AW  = 21,
  parameter int BW  = 2,
  parameter int DW  = 16,
  parameter int NCS = 4
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // memory strobes
  output logic      [NCS-1:0]       mem_select_n,
  output logic                      mem_output_enable_n,
  output logic                      mem_write_strobe_n,
  // memory address
  output logic      [AW-1:0]        ext_word_addr,
  output logic      [BW-1:0]        ext_bank_addr,
  // memory data and wait
  input  wire logic [DW-1:0]        ext_data_bus_in,
  output logic      [DW-1:0]        ext_data_bus_out,
  output logic                      ext_data_bus_oe_n,
  input  wire logic                 ext_wait_in,
  // state
  output amst_pkg::amst_phase_t     phase
);
  import amst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    amst_phase_t         phase;
    logic                is_wr;
    logic                ss_mode;
    logic                ew_mode;
    logic [31:0]         addr_reg;
    logic [DW-1:0]       wdata;
    logic [31:0]         timing;
    logic [7:0]          max_wait;
    logic [8:0]          wait_extension_count;
    logic                wait_seen;
    logic                timeout;
    logic                done;
    logic [DW-1:0]       rdata;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic [NCS-1:0]      cs_n;
    logic                oe_n;
    logic                we_n;
    logic [AW-1:0]       waddr;
    logic [BW-1:0]       baddr;
    logic [DW-1:0]       dout;
    logic                doe_n;
  } amst_state_t;

  amst_state_t s_r;
  amst_state_t s_nxt;

  logic       cnt_load;
  logic [7:0] cnt_val;
  logic [7:0] cnt;
  logic       cnt_last;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] fld(input logic [31:0] r,
                                     input int lsb,
                                     input int w);
    logic [31:0] t;
    t = r >> lsb;
    return 8'(t & ((32'h1 << w) - 32'h1));
  endfunction

  function automatic logic [7:0] eff(input logic [7:0] v);
    return (v == 8'h0) ? 8'h1 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // phase timer

  amst_phase_cnt #(
    .W        (8)
  ) u_cnt (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .cnt      (cnt),
    .last     (cnt_last)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [7:0]  setup_c;
    logic [7:0]  strobe_c;
    logic [7:0]  hold_c;
    logic [7:0]  turn_c;
    logic [8:0]  limit;
    logic        acc_wr;
    logic        go;
    logic        cs_on;
    setup_c  = 8'h0;
    strobe_c = 8'h0;
    hold_c   = 8'h0;
    turn_c   = 8'h0;
    limit    = 9'h0;
    acc_wr   = 1'b0;
    go       = 1'b0;
    cs_on    = 1'b0;
    s_nxt    = s_r;
    cnt_load = 1'b0;
    cnt_val  = 8'h0;

    // counts from software settings
    if (s_r.is_wr)
    begin
      setup_c  = eff(fld(s_r.timing, `AMST_WS_LSB, `AMST_WS_W));
      strobe_c = eff(fld(s_r.timing, `AMST_WST_LSB, `AMST_WST_W));
      hold_c   = eff(fld(s_r.timing, `AMST_WH_LSB, `AMST_WH_W));
    end
    else
    begin
      setup_c  = eff(fld(s_r.timing, `AMST_RS_LSB, `AMST_RS_W));
      strobe_c = eff(fld(s_r.timing, `AMST_RST_LSB, `AMST_RST_W));
      hold_c   = eff(fld(s_r.timing, `AMST_RH_LSB, `AMST_RH_W));
    end
    turn_c = fld(s_r.timing, `AMST_TA_LSB, `AMST_TA_W);
    limit  = (s_r.max_wait == 8'h0) ? `AMST_WAIT_FULL
                                    : {1'b0, s_r.max_wait};

    // apb access phase
    s_nxt.pready  = 1'b0;
    s_nxt.pslverr = 1'b0;
    acc_wr = psel && penable && pwrite && s_r.pready;
    if (psel && !penable)
    begin
      s_nxt.pready = 1'b1;
      s_nxt.prdata = 32'h0;
      unique case (paddr)
        `AMST_OFF_CTRL:
          s_nxt.prdata[3:0] = {s_r.ew_mode, s_r.ss_mode, s_r.is_wr, 1'b0};
        `AMST_OFF_ADDR:    s_nxt.prdata = s_r.addr_reg;
        `AMST_OFF_WDATA:   s_nxt.prdata[DW-1:0] = s_r.wdata;
        `AMST_OFF_TIMING:  s_nxt.prdata = s_r.timing;
        `AMST_OFF_WAITCFG: s_nxt.prdata[7:0] = s_r.max_wait;
        `AMST_OFF_STATUS:
        begin
          s_nxt.prdata[`AMST_ST_BUSY]    = (s_r.phase != AMST_IDLE);
          s_nxt.prdata[`AMST_ST_TIMEOUT] = s_r.timeout;
          s_nxt.prdata[`AMST_ST_DONE]    = s_r.done;
          s_nxt.prdata[`AMST_ST_EWC_LSB +: 9] = s_r.wait_extension_count;
        end
        `AMST_OFF_RDATA:   s_nxt.prdata[DW-1:0] = s_r.rdata;
        default:           s_nxt.pslverr = 1'b1;
      endcase
    end

    // register writes
    if (acc_wr)
    begin
      unique case (paddr)
        `AMST_OFF_CTRL:
        begin
          if (s_r.phase == AMST_IDLE)
          begin
            s_nxt.is_wr   = pwdata[`AMST_CTRL_WR];
            s_nxt.ss_mode = pwdata[`AMST_CTRL_SS];
            s_nxt.ew_mode = pwdata[`AMST_CTRL_EW];
            go            = pwdata[`AMST_CTRL_GO];
          end
        end
        `AMST_OFF_ADDR:    s_nxt.addr_reg = pwdata;
        `AMST_OFF_WDATA:   s_nxt.wdata = pwdata[DW-1:0];
        `AMST_OFF_TIMING:  s_nxt.timing = pwdata;
        `AMST_OFF_WAITCFG: s_nxt.max_wait = pwdata[7:0];
        `AMST_OFF_STATUS:
        begin
          if (pwdata[`AMST_ST_TIMEOUT])
          begin
            s_nxt.timeout = 1'b0;
          end
          if (pwdata[`AMST_ST_DONE])
          begin
            s_nxt.done = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // sequencer, every phase counted in pclk cycles
    unique case (s_r.phase)
      AMST_IDLE:
      begin
        if (go)
        begin
          s_nxt.phase     = AMST_SETUP;
          s_nxt.wait_extension_count       = 9'h0;
          s_nxt.wait_seen = 1'b0;
          cnt_load        = 1'b1;
          // new access sees its own direction before the counts switch
          if (pwdata[`AMST_CTRL_WR])
          begin
            cnt_val = eff(fld(s_r.timing, `AMST_WS_LSB, `AMST_WS_W));
          end
          else
          begin
            cnt_val = eff(fld(s_r.timing, `AMST_RS_LSB, `AMST_RS_W));
          end
        end
      end
      AMST_SETUP:
      begin
        if (cnt_last)
        begin
          s_nxt.phase = AMST_STROBE;
          cnt_load    = 1'b1;
          cnt_val     = strobe_c;
        end
      end
      AMST_STROBE:
      begin
        if (cnt_last)
        begin
          cnt_load = 1'b1;
          if (s_r.ew_mode && ext_wait_in)
          begin
            s_nxt.phase     = AMST_EXTEND;
            s_nxt.wait_extension_count       = 9'h1;
            s_nxt.wait_seen = 1'b1;
            cnt_val         = `AMST_EXT_UNIT;
          end
          else
          begin
            s_nxt.phase = AMST_HOLD;
            cnt_val     = hold_c;
          end
        end
      end
      AMST_EXTEND:
      begin
        if (cnt == `AMST_WAIT_SAMPLE)
        begin
          s_nxt.wait_seen = ext_wait_in;
        end
        if (cnt_last)
        begin
          cnt_load = 1'b1;
          if (s_r.wait_seen && (s_r.wait_extension_count < limit))
          begin
            s_nxt.wait_extension_count = s_r.wait_extension_count + 9'h1;
            cnt_val   = `AMST_EXT_UNIT;
          end
          else
          begin
            if (s_r.wait_seen)
            begin
              s_nxt.timeout = 1'b1;
            end
            s_nxt.phase = AMST_HOLD;
            cnt_val     = hold_c;
          end
        end
      end
      AMST_HOLD:
      begin
        if (cnt_last)
        begin
          s_nxt.done = 1'b1;
          if (turn_c != 8'h0)
          begin
            s_nxt.phase = AMST_TURN;
            cnt_load    = 1'b1;
            cnt_val     = turn_c;
          end
          else
          begin
            s_nxt.phase = AMST_IDLE;
          end
        end
      end
      AMST_TURN:
      begin
        if (cnt_last)
        begin
          s_nxt.phase = AMST_IDLE;
        end
      end
    endcase

    // read data taken on the last strobe or extension cycle
    if (!s_r.is_wr && (s_nxt.phase == AMST_HOLD)
        && (s_r.phase != AMST_HOLD))
    begin
      s_nxt.rdata = ext_data_bus_in;
    end

    // pins follow the coming phase so they leave flip-flops in step
    unique case (s_nxt.phase)
      AMST_SETUP, AMST_HOLD: cs_on = !s_nxt.ss_mode;
      AMST_STROBE, AMST_EXTEND: cs_on = 1'b1;
      default: cs_on = 1'b0;
    endcase
    s_nxt.cs_n = '1;
    if (cs_on)
    begin
      s_nxt.cs_n[s_nxt.addr_reg[`AMST_ADDR_CS_LSB +: 2]] = 1'b0;
    end
    s_nxt.oe_n = !(!s_nxt.is_wr && ((s_nxt.phase == AMST_STROBE)
                   || (s_nxt.phase == AMST_EXTEND)));
    s_nxt.we_n = !(s_nxt.is_wr && ((s_nxt.phase == AMST_STROBE)
                   || (s_nxt.phase == AMST_EXTEND)));
    if (s_r.phase == AMST_IDLE && s_nxt.phase == AMST_SETUP)
    begin
      // address and bank stand from setup start through hold end
      s_nxt.waddr = s_nxt.addr_reg[AW-1:0];
      s_nxt.baddr = s_nxt.addr_reg[`AMST_ADDR_BANK_LSB +: BW];
      s_nxt.dout  = s_nxt.wdata;
    end
    s_nxt.doe_n = !(s_nxt.is_wr && (s_nxt.phase != AMST_IDLE)
                    && (s_nxt.phase != AMST_TURN));
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r          <= '0;
      s_r.phase    <= AMST_IDLE;
      s_r.timing   <= `AMST_TIMING_RST;
      s_r.max_wait <= `AMST_WAITCFG_RST;
      s_r.cs_n     <= '1;
      s_r.oe_n     <= 1'b1;
      s_r.we_n     <= 1'b1;
      s_r.doe_n    <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready              = s_r.pready;
  assign prdata              = s_r.prdata;
  assign pslverr             = s_r.pslverr;
  assign mem_select_n        = s_r.cs_n;
  assign mem_output_enable_n = s_r.oe_n;
  assign mem_write_strobe_n  = s_r.we_n;
  assign ext_word_addr       = s_r.waddr;
  assign ext_bank_addr       = s_r.baddr;
  assign ext_data_bus_out    = s_r.dout;
  assign ext_data_bus_oe_n   = s_r.doe_n;
  assign phase               = s_r.phase;

endmodule

// ---- dv/amst_mem.sv ----
// memory model with programmable wait stretching
`timescale 1ns/1ps
module amst_mem (
  // clock
  input  wire logic        pclk,
  // memory pins
  input  wire logic [3:0]  mem_select_n,
  input  wire logic        mem_output_enable_n,
  input  wire logic        mem_write_strobe_n,
  input  wire logic [15:0] ext_data_bus_out,
  output logic      [15:0] ext_data_bus_in,
  output logic             ext_wait_in,
  // wait cycles asked per strobe
  input  wire logic [7:0]  wait_len
);
  logic [15:0] word_r;
  logic [15:0] junk_r = 16'h0f0f;
  logic [7:0]  stb_r = 8'h00;
  wire         sel = !(&mem_select_n);
  wire         stb = !mem_output_enable_n || !mem_write_strobe_n;
  // drive only while read strobe low, else a moving pattern
  assign ext_data_bus_in = (sel && !mem_output_enable_n) ? word_r : junk_r;
  // stretch the first wait_len strobe cycles
  assign ext_wait_in = stb && (stb_r < wait_len);
  always @(posedge pclk)
  begin
    junk_r <= ~junk_r;
    stb_r <= stb ? stb_r + 8'h01 : 8'h00;
    if (sel && !mem_write_strobe_n)
      word_r <= ext_data_bus_out;
  end
endmodule

// ---- dv/amst_ctrl_assertions.sv ----
// pin timing checker for the strobe sequencer
`timescale 1ns/1ps
module amst_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // memory pins
  input wire logic [3:0]  mem_select_n,
  input wire logic        mem_output_enable_n,
  input wire logic        mem_write_strobe_n,
  input wire logic [20:0] ext_word_addr,
  input wire amst_pkg::amst_phase_t phase
);
  import amst_pkg::*;
  logic [31:0] tim_r;
  logic [3:0]  ctl_r;
  logic [7:0]  sel_c, oe_c, we_c, idl_c;
  wire         cs_n = &mem_select_n;
  wire         wr_x = psel && penable && pready && pwrite;
  function automatic logic [7:0] nz(input logic [5:0] v);
    return (v == 6'h00) ? 8'h01 : {2'h0, v};
  endfunction
  wire [7:0] r_set = nz({2'h0, tim_r[3:0]});
  wire [7:0] r_stb = nz(tim_r[9:4]);
  wire [7:0] r_hld = nz({2'h0, tim_r[13:10]});
  wire [7:0] w_set = nz({2'h0, tim_r[17:14]});
  wire [7:0] w_stb = nz(tim_r[23:18]);
  wire [7:0] w_hld = nz({2'h0, tim_r[27:24]});
  wire [7:0] t_gap = {4'h0, tim_r[31:28]};
  ////////////////////////////////////////////////////////////////////////
  // config snoop and phase counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tim_r <= 32'h0000_0000;
      ctl_r <= 4'h0;
      sel_c <= 8'h00;
      oe_c  <= 8'h00;
      we_c  <= 8'h00;
      idl_c <= 8'hff;
    end
    else
    begin
      if (wr_x && paddr == 8'h0c)
        tim_r <= pwdata;
      if (wr_x && paddr == 8'h00 && phase == AMST_IDLE)
        ctl_r <= pwdata[3:0];
      sel_c <= cs_n ? 8'h00 : sel_c + 8'h01;
      oe_c  <= mem_output_enable_n ? 8'h00 : oe_c + 8'h01;
      we_c  <= mem_write_strobe_n ? 8'h00 : we_c + 8'h01;
      idl_c <= !cs_n ? 8'h00 : idl_c + {7'h0, idl_c != 8'hff};
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_width(logic s, logic [7:0] c, logic [7:0] t);
    $rose(s) |-> (ctl_r[3] ? (c >= t && ((c - t) & 8'h0f) == 8'h00)
                           : c == t);
  endproperty
  chk_apb_zero_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle");
  chk_oe_width: assert property (p_width(mem_output_enable_n, oe_c, r_stb))
    else $error("read strobe width off");
  chk_we_width: assert property (p_width(mem_write_strobe_n, we_c, w_stb))
    else $error("write strobe width off");
  chk_sel_lead: assert property (($fell(mem_output_enable_n) ||
    $fell(mem_write_strobe_n)) && !ctl_r[2] |->
    sel_c == (ctl_r[1] ? w_set : r_set))
    else $error("select lead off");
  chk_sel_track: assert property (ctl_r[2] |->
    cs_n == (mem_output_enable_n && mem_write_strobe_n))
    else $error("select not tracking strobe");
  chk_access_total: assert property ($rose(cs_n) && ctl_r[3:2] == 2'b00
    |-> sel_c == (ctl_r[1] ? w_set + w_stb + w_hld : r_set + r_stb + r_hld))
    else $error("access length off");
  chk_addr_hold: assert property (!cs_n && !$past(cs_n)
    |-> $stable(ext_word_addr))
    else $error("address moved during access");
  chk_turn_gap: assert property ($fell(cs_n) |-> idl_c >= t_gap)
    else $error("turnaround gap short");
  cover property ($rose(mem_output_enable_n) && ctl_r[3]);
  cover property ($rose(mem_write_strobe_n));
  cover property (ctl_r[2] && !cs_n);
endmodule
bind amst_ctrl amst_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .mem_select_n, .mem_output_enable_n,
  .mem_write_strobe_n, .ext_word_addr, .phase);

// ---- dv/tb_top.sv ----
// self-checking bench for the strobe sequencer
`timescale 1ns/1ps
module tb_top;
  import amst_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, mem_output_enable_n, mem_write_strobe_n;
  logic        ext_data_bus_oe_n, ext_wait_in, err;
  logic [31:0] prdata, q, av;
  logic [3:0]  mem_select_n;
  logic [20:0] ext_word_addr;
  logic [1:0]  ext_bank_addr;
  logic [15:0] ext_data_bus_in, ext_data_bus_out;
  logic [7:0]  wait_len = 8'h00;
  amst_phase_t phase;
  int          bad_count = 0;
  int          comparisons = 0;
  int          n_oe, n_we, n_cs, n_de;
  always #2.5 pclk = ~pclk;
  amst_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .mem_select_n,
    .mem_output_enable_n, .mem_write_strobe_n, .ext_word_addr,
    .ext_bank_addr, .ext_data_bus_in, .ext_data_bus_out,
    .ext_data_bus_oe_n, .ext_wait_in, .phase);
  amst_mem mem_u (.pclk, .mem_select_n, .mem_output_enable_n,
    .mem_write_strobe_n, .ext_data_bus_out, .ext_data_bus_in,
    .ext_wait_in, .wait_len);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk32(q, exp);
  endtask
  // start one access and count strobe cycles until idle
  task automatic go(input logic [31:0] c, input logic [7:0] wl);
    int n = 0;
    n_oe = 0;
    n_we = 0;
    n_cs = 0;
    n_de = 0;
    av = 32'h0;
    wait_len <= wl;
    apb(1'b1, 8'h00, c);
    do
    begin
      @(posedge pclk);
      n++;
      n_oe += int'(mem_output_enable_n === 1'b0);
      n_we += int'(mem_write_strobe_n === 1'b0);
      n_cs += int'(mem_select_n !== 4'hf);
      n_de += int'(ext_data_bus_oe_n === 1'b0);
      if (mem_select_n !== 4'hf)
        av = {mem_select_n, 5'h00, ext_bank_addr, ext_word_addr};
    end
    while (phase !== AMST_IDLE && n < 300);
    if (phase !== AMST_IDLE)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, phase,
               AMST_IDLE);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(8'h0c, 32'h0);
    rdc(8'h1c, 32'h0);
    chk32({31'h0, err}, 32'h1);
    apb(1'b1, 8'h0c, 32'h3208_c432);
    rdc(8'h0c, 32'h3208_c432);
    apb(1'b1, 8'h04, 32'h0140_0005);
    apb(1'b1, 8'h08, 32'h0000_beef);
    go(32'h3, 8'h00);
    chk32(n_we, 2);
    chk32(n_cs, 7);
    chk32(n_de, 7);
    chk32(av, 32'hd040_0005);
    go(32'h1, 8'h00);
    chk32(n_oe, 3);
    chk32(n_cs, 6);
    chk32(n_de, 0);
    chk32(av, 32'hd040_0005);
    rdc(8'h18, 32'h0000_beef);
    go(32'h5, 8'h00);
    chk32(n_cs, 3);
    chk32(n_oe, 3);
    go(32'h7, 8'h00);
    chk32(n_cs, 2);
    apb(1'b1, 8'h10, 32'h2);
    go(32'h9, 8'h08);
    chk32(n_oe, 19);
    chk32(n_cs, 22);
    rdc(8'h14, 32'h0000_0104);
    apb(1'b1, 8'h14, 32'h6);
    rdc(8'h14, 32'h0000_0100);
    go(32'hb, 8'hc8);
    chk32(n_we, 34);
    apb(1'b0, 8'h14, 32'h0);
    chk32(q & 32'h0001_ff02, 32'h0000_0202);
    apb(1'b1, 8'h0c, 32'h0);
    go(32'h1, 8'h00);
    chk32(n_oe, 1);
    chk32(n_cs, 3);
    stop_test();
  end
endmodule
